//--- core/vr_seq_defines.svh
`ifndef VR_SEQ_DEFINES_SVH
`define VR_SEQ_DEFINES_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CTRL 8'h00
`define OFS_BUS_ADDR 8'h04
`define OFS_VID_OFS 8'h08
`define OFS_CUR_OFS 8'h0C
`define OFS_TEMP_OFS 8'h10
`define OFS_BCAST 8'h14
`define OFS_BOOT 8'h18
`define OFS_SPLIT_DLY 8'h1C
`define OFS_VID_REQ 8'h20
`define OFS_STATUS 8'h24
`define OFS_TARGET 8'h28
`define OFS_REPORT 8'h2C
`define OFS_SLEW 8'h30
// ************************************************************
// Control register fields and reset values
// ************************************************************
`define CTRL_LOCK 0
`define CTRL_PIN_OFS_EN 1
`define CTRL_MODE_10MV 2
`define CTRL_MOBILE 3
`define CTRL_BOOT_10MV 4
`define CTRL_SPLIT 5
`define CTRL_ORDER_LO 6
`define CTRL_DSEL_LO 8
`define CTRL_RESET 12'h001
`define BUS_ADDR_RESET 4'h0
`define SLEEP_CMD_BIT 24
`define STAT_DAC_HIGH 3
`define BCAST_A 4'hE
`define BCAST_B 4'hF
`define PIN_OFS_MAX 3'h6
// ************************************************************
// Voltage decode and timing
// ************************************************************
`define VID_5MV_BASE_MV 12'd245
`define VID_10MV_BASE_MV 12'd490
`define DAC_HIGH_MV 12'd30
`define CLK_PERIOD_NS 8
`define T_EN_TO_L1_NS 3000
`define T_READY_MAX_NS 1000
`define T_SPLIT_STEP_NS 2660
`define T_DLY1_NS 250000
`define T_DLY2_NS 500000
`define T_DLY3_NS 1000000
`define T_DLY4_NS 2500000
`define T_DLY5_NS 5000000
`define T_DLY6_NS 10000000
`endif

//--- core/vr_seq_pkg.sv
package vr_seq_pkg;
    typedef enum logic [1:0] {ORD_TOGETHER, ORD_L2_AFTER_L1, ORD_L1_AFTER_L2, ORD_SPARE} order_t;
    typedef enum logic [1:0] {BC_BOTH, BC_E_ONLY, BC_F_ONLY, BC_NONE} bcast_t;
    typedef enum {SQ_OFF, SQ_LEAD, SQ_GAP, SQ_ON} seq_state_t;
endpackage

//--- core/vr_vid_config_and_loop_sequencer.sv
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "vr_seq_defines.svh"

module vr_vid_config_and_loop_sequencer #(
    parameter int unsigned T_LEAD_CYC = `T_EN_TO_L1_NS / `CLK_PERIOD_NS,
    parameter int unsigned SPLIT_STEP_CYC = `T_SPLIT_STEP_NS / `CLK_PERIOD_NS,
    parameter int unsigned DLY1_CYC = `T_DLY1_NS / `CLK_PERIOD_NS,
    parameter int unsigned DLY2_CYC = `T_DLY2_NS / `CLK_PERIOD_NS,
    parameter int unsigned DLY3_CYC = `T_DLY3_NS / `CLK_PERIOD_NS,
    parameter int unsigned DLY4_CYC = `T_DLY4_NS / `CLK_PERIOD_NS,
    parameter int unsigned DLY5_CYC = `T_DLY5_NS / `CLK_PERIOD_NS,
    parameter int unsigned DLY6_CYC = `T_DLY6_NS / `CLK_PERIOD_NS
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins from outside the clock domain.
    input wire logic regulator_enable_input,
    input wire logic [2:0] addr_pin_code,
    // Serial bus framer and telemetry, same clock.
    input wire logic [3:0] query_addr,
    input wire logic [11:0] raw_current,
    input wire logic [7:0] raw_temp,
    // Loop outputs.
    output logic [1:0] loop_addr_hit,
    output logic [7:0] loop1_dac,
    output logic [7:0] loop2_dac,
    output logic [11:0] loop1_target_mv,
    output logic loop1_ready_output,
    output logic loop2_ready_output,
    output logic dac_above_target_flag,
    output logic [11:0] current_report,
    output logic [7:0] temp_report
);
    import vr_seq_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic en_m_q, en_s_q;
    logic [2:0] pin_m_q, pin_s_q;

    // Both pins cross two flops before any logic looks at them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
            pin_m_q <= 3'h0;
            pin_s_q <= 3'h0;
        end else begin
            en_m_q <= regulator_enable_input;
            en_s_q <= en_m_q;
            pin_m_q <= addr_pin_code;
            pin_s_q <= pin_m_q;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [11:0] ctrl_q;
    logic [3:0] bus_addr_q;
    logic signed [7:0] vid_ofs_q;
    logic signed [4:0] cur_ofs_q;
    logic signed [5:0] temp_ofs_q;
    logic [3:0] bcast_q;
    logic [15:0] boot_q;
    logic [7:0] split_dly_q;
    logic [15:0] slew_q;
    logic [7:0] req_q [2];
    logic sleep_q;
    logic [7:0] tgt_q [2];
    logic [7:0] dac_q [2];
    logic [1:0] go_q, rdy_q;
    seq_state_t st_q;
    logic [3:0] eff_addr;

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    logic aw_full_q, w_full_q;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_go, mapped_w;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;
    assign s_axi_rresp = 2'h0;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data are held separately so either may arrive first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign mapped_w = wr_go && ws_q[0];

    // Configuration writes; low byte lane must be enabled for any effect.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `CTRL_RESET;
            bus_addr_q <= `BUS_ADDR_RESET;
            vid_ofs_q <= 8'sh00;
            cur_ofs_q <= 5'sh00;
            temp_ofs_q <= 6'sh00;
            bcast_q <= 4'h0;
            boot_q <= 16'h0000;
            split_dly_q <= 8'h00;
            slew_q <= 16'h0000;
        end else if (mapped_w) begin
            case (aw_q)
                `OFS_CTRL: ctrl_q <= wd_q[11:0];
                `OFS_BUS_ADDR: begin
                    if (!ctrl_q[`CTRL_LOCK]) begin
                        bus_addr_q <= wd_q[3:0];
                    end
                end
                `OFS_VID_OFS: vid_ofs_q <= wd_q[7:0];
                `OFS_CUR_OFS: cur_ofs_q <= wd_q[4:0];
                `OFS_TEMP_OFS: temp_ofs_q <= wd_q[5:0];
                `OFS_BCAST: bcast_q <= wd_q[3:0];
                `OFS_BOOT: boot_q <= wd_q[15:0];
                `OFS_SPLIT_DLY: split_dly_q <= wd_q[7:0];
                `OFS_SLEW: slew_q <= wd_q[15:0];
                default: ;
            endcase
        end
    end

    // Read path; unmapped offsets read as zero with an OKAY answer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `OFS_CTRL: s_axi_rdata <= {20'h00000, ctrl_q};
                `OFS_BUS_ADDR: s_axi_rdata <= {28'h0000000, bus_addr_q};
                `OFS_VID_OFS: s_axi_rdata <= {24'h000000, vid_ofs_q};
                `OFS_CUR_OFS: s_axi_rdata <= {27'h0000000, cur_ofs_q};
                `OFS_TEMP_OFS: s_axi_rdata <= {26'h0000000, temp_ofs_q};
                `OFS_BCAST: s_axi_rdata <= {28'h0000000, bcast_q};
                `OFS_BOOT: s_axi_rdata <= {16'h0000, boot_q};
                `OFS_SPLIT_DLY: s_axi_rdata <= {24'h000000, split_dly_q};
                `OFS_SLEW: s_axi_rdata <= {16'h0000, slew_q};
                `OFS_VID_REQ: s_axi_rdata <= {16'h0000, req_q[1], req_q[0]};
                `OFS_STATUS: s_axi_rdata <= {20'h00000, eff_addr, 3'h0, sleep_q,
                    dac_above_target_flag, 1'b0, rdy_q};
                `OFS_TARGET: s_axi_rdata <= {dac_q[1], dac_q[0], tgt_q[1], tgt_q[0]};
                `OFS_REPORT: s_axi_rdata <= {8'h00, temp_report, 4'h0, current_report};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Addressing
    // ************************************************************
    logic [2:0] pin_ofs;

    // Codes above the last resistor setting clamp to the largest offset.
    assign pin_ofs = (pin_s_q > `PIN_OFS_MAX) ? `PIN_OFS_MAX : pin_s_q;
    assign eff_addr = bus_addr_q + (ctrl_q[`CTRL_PIN_OFS_EN] ? {1'b0, pin_ofs} : 4'h0);

    // Loop 1 answers at the effective address, loop 2 one above it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_addr_hit <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                loop_addr_hit[i] <= (query_addr == eff_addr + 4'(i)) ||
                    (query_addr == `BCAST_A && (bcast_t'(bcast_q[2*i+:2]) inside {BC_BOTH, BC_E_ONLY})) ||
                    (query_addr == `BCAST_B && (bcast_t'(bcast_q[2*i+:2]) inside {BC_BOTH, BC_F_ONLY}));
            end
        end
    end

    // ************************************************************
    // VID requests and targets
    // ************************************************************
    logic en_rise;
    logic step10;
    logic split;
    logic [8:0] sum [2];

    assign en_rise = en_s_q && st_q == SQ_OFF;
    assign split = ctrl_q[`CTRL_SPLIT];
    // Mobile mode takes its step choice from the boot step bit, for every code.
    assign step10 = ctrl_q[`CTRL_MOBILE] ? ctrl_q[`CTRL_BOOT_10MV] : ctrl_q[`CTRL_MODE_10MV];

    // Boot codes load at enable; set-target writes load later. Either bus
    // path lands here, so split mode needs no separate control port.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q[0] <= 8'h00;
            req_q[1] <= 8'h00;
            sleep_q <= 1'b0;
        end else if (en_rise) begin
            req_q[0] <= boot_q[7:0];
            req_q[1] <= boot_q[15:8];
            sleep_q <= 1'b0;
        end else if (mapped_w && aw_q == `OFS_VID_REQ) begin
            if (wd_q[`SLEEP_CMD_BIT]) begin
                sleep_q <= ctrl_q[`CTRL_MOBILE];
            end else begin
                req_q[0] <= wd_q[7:0];
                req_q[1] <= wd_q[15:8];
                sleep_q <= 1'b0;
            end
        end
    end

    // Offset sum in nine signed bits, then clamped to codes 00..FF.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sum[i] = 9'({1'b0, req_q[i]} + {vid_ofs_q[7], vid_ofs_q});
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tgt_q[0] <= 8'h00;
            tgt_q[1] <= 8'h00;
        end else begin
            // A negative sum floors at zero and a carry caps at the top code.
            for (int i = 0; i < 2; i++) begin
                if (vid_ofs_q[7] && sum[i][8]) begin
                    tgt_q[i] <= 8'h00;
                end else if (sum[i][8]) begin
                    tgt_q[i] <= 8'hFF;
                end else begin
                    tgt_q[i] <= sum[i][7:0];
                end
            end
            if (split) begin
                tgt_q[1] <= {1'b0, (vid_ofs_q[7] && sum[0][8]) ? 7'h00 :
                    (sum[0][8] ? 7'h7F : sum[0][7:1])};
            end
        end
    end

    // ************************************************************
    // Voltage decode and DAC-high flag
    // ************************************************************
    function automatic logic [11:0] code_mv(input logic [7:0] code, input logic ten);
        logic [11:0] v;
        v = 12'h000;
        if (code != 8'h00) begin
            v = ten ? 12'(`VID_10MV_BASE_MV + 12'd10 * code) : 12'(`VID_5MV_BASE_MV + 12'd5 * code);
        end
        return v;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop1_target_mv <= 12'h000;
            dac_above_target_flag <= 1'b0;
        end else begin
            loop1_target_mv <= code_mv(tgt_q[0], step10);
            // Level flag; it clears once the DAC has come down.
            dac_above_target_flag <= ctrl_q[`CTRL_MOBILE] &&
                code_mv(dac_q[0], step10) > 12'(code_mv(tgt_q[0], step10) + `DAC_HIGH_MV);
        end
    end

    // ************************************************************
    // Start sequencer
    // ************************************************************
    logic [23:0] cnt_q;
    logic [23:0] gap_cyc;
    order_t order;
    logic lead_l1;

    assign order = split ? ORD_L2_AFTER_L1 : order_t'(ctrl_q[`CTRL_ORDER_LO+:2]);
    assign lead_l1 = order != ORD_L1_AFTER_L2;

    always_comb begin
        if (split) begin
            gap_cyc = 24'(split_dly_q * SPLIT_STEP_CYC);
        end else begin
            case (ctrl_q[`CTRL_DSEL_LO+:3])
                3'h1: gap_cyc = 24'(DLY1_CYC);
                3'h2: gap_cyc = 24'(DLY2_CYC);
                3'h3: gap_cyc = 24'(DLY3_CYC);
                3'h4: gap_cyc = 24'(DLY4_CYC);
                3'h5: gap_cyc = 24'(DLY5_CYC);
                3'h6: gap_cyc = 24'(DLY6_CYC);
                default: gap_cyc = 24'h000000;
            endcase
        end
    end

    // Dropping enable stops both loops at once, whatever the state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= SQ_OFF;
            cnt_q <= 24'h000000;
            go_q <= 2'b00;
        end else if (!en_s_q) begin
            st_q <= SQ_OFF;
            go_q <= 2'b00;
        end else begin
            case (st_q)
                SQ_OFF: begin
                    cnt_q <= split ? 24'(T_LEAD_CYC - 1) : 24'h000000;
                    st_q <= SQ_LEAD;
                end
                SQ_LEAD: begin
                    if (cnt_q != 24'h000000) begin
                        cnt_q <= cnt_q - 24'h000001;
                    end else if (order == ORD_TOGETHER || order == ORD_SPARE) begin
                        go_q <= 2'b11;
                        st_q <= SQ_ON;
                    end else begin
                        go_q <= lead_l1 ? 2'b01 : 2'b10;
                        cnt_q <= gap_cyc;
                        st_q <= SQ_GAP;
                    end
                end
                SQ_GAP: begin
                    if (cnt_q != 24'h000000) begin
                        cnt_q <= cnt_q - 24'h000001;
                    end else begin
                        go_q <= 2'b11;
                        st_q <= SQ_ON;
                    end
                end
                SQ_ON: ;
                default: st_q <= SQ_OFF;
            endcase
        end
    end

    // ************************************************************
    // Loop ramps and ready outputs
    // ************************************************************
    logic [7:0] slew_cnt_q [2];

    // One code per slew period; slew registers are the user's to match.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 2; i++) begin
                dac_q[i] <= 8'h00;
                slew_cnt_q[i] <= 8'h00;
                rdy_q[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!go_q[i]) begin
                    dac_q[i] <= 8'h00;
                    slew_cnt_q[i] <= 8'h00;
                end else if (slew_cnt_q[i] != 8'h00) begin
                    slew_cnt_q[i] <= slew_cnt_q[i] - 8'h01;
                end else if (dac_q[i] != tgt_q[i]) begin
                    dac_q[i] <= dac_q[i] < tgt_q[i] ? dac_q[i] + 8'h01 : dac_q[i] - 8'h01;
                    slew_cnt_q[i] <= slew_q[8*i+:8];
                end
                // One cycle after the ramp lands, well inside the limit.
                rdy_q[i] <= go_q[i] && dac_q[i] == tgt_q[i];
            end
        end
    end

    assign loop1_dac = dac_q[0];
    assign loop2_dac = dac_q[1];
    assign loop1_ready_output = rdy_q[0];
    assign loop2_ready_output = rdy_q[1];

    // ************************************************************
    // Telemetry reporting offsets
    // ************************************************************
    logic signed [13:0] cur_sum;
    logic signed [9:0] temp_sum;

    assign cur_sum = $signed({2'b00, raw_current}) + 14'(cur_ofs_q);
    assign temp_sum = $signed({2'b00, raw_temp}) + 10'(temp_ofs_q);

    // Reports clamp at zero so a negative trim never wraps large.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            current_report <= 12'h000;
            temp_report <= 8'h00;
        end else begin
            current_report <= cur_sum[13] ? 12'h000 : (cur_sum[12] ? 12'hFFF : cur_sum[11:0]);
            temp_report <= temp_sum[9] ? 8'h00 : (temp_sum[8] ? 8'hFF : temp_sum[7:0]);
        end
    end
endmodule

//--- verification/vr_seq_checker.sv
`timescale 1ns/1ps
// ************************************************************
// Port checks for the sequencer
// ************************************************************
module vr_seq_checker (
    // Clock, reset and bus handshakes.
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Enable pin and loop outputs.
    input wire logic regulator_enable_input, loop1_ready_output, loop2_ready_output,
    input wire logic [7:0] loop1_dac, loop2_dac,
    input wire logic [11:0] loop1_target_mv
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken on one edge.
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Enable low long enough to clear the two-flop synchroniser.
    sequence enable_gone;
        !regulator_enable_input [*3];
    endsequence
    a_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_target_cap: assert property (loop1_target_mv <= 12'd3040)
        else $error("target above top code");
    a_dac_drop: assert property (enable_gone |-> ##2 loop1_dac == 8'h00 && loop2_dac == 8'h00)
        else $error("dac kept after disable");
    a_ready_drop: assert property (enable_gone ##1 !regulator_enable_input |=> !loop1_ready_output
        && !loop2_ready_output)
        else $error("ready kept after disable");
    a_ready_steady: assert property ($rose(loop1_ready_output) |-> $stable(loop1_dac))
        else $error("ready while ramping");
endmodule
bind vr_vid_config_and_loop_sequencer vr_seq_checker chk_i (.*);

//--- verification/vr_seq_partner.sv
`timescale 1ns/1ps
// ************************************************************
// Board pins on a slow clock of their own
// ************************************************************
module vr_seq_partner (
    // Pins seen by the block.
    output logic regulator_enable_input,
    output logic [2:0] addr_pin_code
);
    logic lclk = 1'b0;
    logic en_req = 1'b0;
    logic [2:0] pin_req = 3'h0;
    // Offset by 1 ns so pin edges never meet a core clock edge.
    initial begin
        regulator_enable_input = 1'b0;
        addr_pin_code = 3'h0;
        #1;
        forever #80 lclk = ~lclk;
    end
    // Pins move only on link edges, so the block must synchronise them.
    always @(posedge lclk) begin
        regulator_enable_input <= en_req;
        addr_pin_code <= pin_req;
    end
endmodule

//--- verification/vr_vid_config_and_loop_sequencer_bench.sv
`timescale 1ns/1ps
`include "vr_seq_defines.svh"
// ************************************************************
// Self-checking bench
// ************************************************************
module vr_vid_config_and_loop_sequencer_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, regulator_enable_input;
    logic loop1_ready_output, loop2_ready_output, dac_above_target_flag;
    logic [7:0] s_axi_awaddr, s_axi_araddr, loop1_dac, loop2_dac, raw_temp, temp_report;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, query_addr;
    logic [1:0] s_axi_bresp, s_axi_rresp, loop_addr_hit;
    logic [2:0] addr_pin_code;
    logic [11:0] raw_current, loop1_target_mv, current_report;
    int err_count = 0;
    int checks = 0;
    // Short delays keep the run brief; expectations below use these values.
    vr_vid_config_and_loop_sequencer #(.T_LEAD_CYC(4), .SPLIT_STEP_CYC(2), .DLY1_CYC(5), .DLY2_CYC(10)) uut (.*);
    vr_seq_partner pm (.regulator_enable_input, .addr_pin_code);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic report_and_stop;
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic hang;
        err_count++;
        report_and_stop();
    endtask
    // Handshakes are read on the falling edge, settled for the next rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] p = 3'b111;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
        for (int n = 0; n < 64 && p != 3'b000; n++) begin
            @(negedge aclk);
            p = p & ~{s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid & s_axi_bready};
            @(posedge aclk);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
        end
        if (p != 3'b000) hang();
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [1:0] p = 2'b11;
        logic [31:0] d = '0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= p;
        for (int n = 0; n < 64 && p != 2'b00; n++) begin
            @(negedge aclk);
            if (s_axi_rvalid && s_axi_rready) d = s_axi_rdata;
            p = p & ~{s_axi_arvalid & s_axi_arready, s_axi_rvalid & s_axi_rready};
            @(posedge aclk);
            {s_axi_arvalid, s_axi_rready} <= p;
        end
        if (p != 2'b00) hang();
        chk(nm, d & m, exp);
    endtask
    task automatic ask(input logic [3:0] q, input logic [1:0] exp);
        @(posedge aclk);
        query_addr <= q;
        @(posedge aclk);
        @(negedge aclk);
        chk("loop_addr_hit", 32'(loop_addr_hit), 32'(exp));
    endtask
    task automatic t_address;
        rc("ctrl", `OFS_CTRL, 32'hFFFF_FFFF, 32'h1);
        rc("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
        ask(4'h0, 2'b01);
        wr(`OFS_BUS_ADDR, 32'h5);
        rc("guarded", `OFS_STATUS, 32'hF00, 32'h000);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_BUS_ADDR, 32'h5);
        wr(`OFS_CTRL, 32'h1);
        pm.pin_req = 3'h6;
        repeat (60) @(posedge aclk);
        rc("pin off", `OFS_STATUS, 32'hF00, 32'h500);
        wr(`OFS_CTRL, 32'h3);
        rc("pin on", `OFS_STATUS, 32'hF00, 32'hB00);
        ask(4'hB, 2'b01);
        ask(4'hC, 2'b10);
        wr(`OFS_CTRL, 32'h1);
    endtask
    task automatic t_seq;
        logic [31:0] cfg[4] = '{32'h141, 32'h281, 32'h001, 32'h021};
        logic [1:0] lead[4] = '{2'b10, 2'b01, 2'b11, 2'b10};
        int gap[4] = '{6, 11, 0, 7};
        int n;
        wr(`OFS_SPLIT_DLY, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_CTRL, cfg[i]);
            pm.en_req = 1'b1;
            for (n = 0; n < 2000 && !(loop1_ready_output | loop2_ready_output); n++) @(negedge aclk);
            if (n == 2000) hang();
            chk("first ready", 32'({loop1_ready_output, loop2_ready_output}), 32'(lead[i]));
            for (n = 0; n < 200 && !(loop1_ready_output & loop2_ready_output); n++) @(negedge aclk);
            chk("start gap", 32'(n), 32'(gap[i]));
            pm.en_req = 1'b0;
            for (n = 0; n < 200 && (loop1_ready_output | loop2_ready_output); n++) @(negedge aclk);
            if (n == 200) hang();
        end
        wr(`OFS_CTRL, 32'h1);
    endtask
    task automatic t_bcast;
        logic [3:0] bc[4] = '{4'h9, 4'h6, 4'h0, 4'hF};
        logic [1:0] he[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
        logic [1:0] hf[4] = '{2'b10, 2'b01, 2'b11, 2'b00};
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_BCAST, 32'(bc[i]));
            ask(`BCAST_A, he[i]);
            ask(`BCAST_B, hf[i]);
        end
    endtask
    task automatic t_vid;
        wr(`OFS_SLEW, 32'h0402);
        wr(`OFS_VID_REQ, 32'h47);
        repeat (4) @(posedge aclk);
        chk("target mv", 32'(loop1_target_mv), 32'd600);
        wr(`OFS_VID_OFS, 32'h7F);
        wr(`OFS_VID_REQ, 32'hF0);
        rc("saturated", `OFS_TARGET, 32'hFF, 32'hFF);
        wr(`OFS_CTRL, 32'h25);
        rc("split", `OFS_TARGET, 32'hFFFF, 32'h7FFF);
        chk("top mv", 32'(loop1_target_mv), 32'd3040);
        wr(`OFS_VID_OFS, 32'h80);
        wr(`OFS_VID_REQ, 32'h90);
        rc("negative", `OFS_TARGET, 32'hFF, 32'h10);
    endtask
    task automatic t_rep;
        @(posedge aclk);
        raw_current <= 12'd100;
        raw_temp <= 8'd50;
        wr(`OFS_CUR_OFS, 32'h10);
        wr(`OFS_TEMP_OFS, 32'h1F);
        repeat (2) @(negedge aclk);
        chk("current", 32'(current_report), 32'd84);
        chk("temp", 32'(temp_report), 32'd81);
        wr(`OFS_TEMP_OFS, 32'h20);
        raw_temp <= 8'd10;
        repeat (3) @(negedge aclk);
        chk("temp floor", 32'(temp_report), 32'd0);
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, query_addr, raw_current, raw_temp} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_address();
        t_seq();
        t_bcast();
        t_vid();
        t_rep();
        report_and_stop();
    end
endmodule
